// ---- logic/fplc_top.sv ----
// flash launch control: key sequence, status flags and space steering
// assumes sfr, code and xdata requests arrive as one-cycle strobes on clk
//
// Summary of operation
// - bad launch sequence sets the error flag
// - software clears error; good launch clears it
// - code reads default to user array, read-only
// - latch space select redirects xdata writes
// - low seven bits byte, upper nine page
// - latch space select overrides external ram select
// - mode field maps code reads to spaces
// - key 5 then A launches per mode
// - mode 11 launch clears column latches
// - busy flag is hardware only
// - latch buffer holds one 128-byte page
// - launch with empty latches flags error unless mode is 11
`default_nettype none
module fplc_top (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // special function register access
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    // auxiliary register bit from the core
    input wire logic external_ram_select,
    // code space reads
    input wire logic code_rd,
    input wire logic [15:0] code_addr,
    output logic code_rd_en,
    output fplc_pkg::fplc_mode_t code_rd_space,
    output logic [15:0] code_rd_addr,
    // external data writes
    input wire logic xdata_wr,
    input wire logic [15:0] xdata_addr,
    input wire logic [7:0] xdata_wdata,
    output logic xram_wr_int,
    output logic xram_wr_ext,
    output logic [15:0] xram_addr,
    output logic [7:0] xram_wdata,
    // flash array programming engine
    input wire logic prog_done,
    input wire logic [6:0] prog_rd_idx,
    output logic prog_start,
    output fplc_pkg::fplc_mode_t prog_mode,
    output logic [8:0] prog_page,
    output logic [7:0] prog_rd_data,
    output logic prog_rd_valid
);
    fplc_latch_if lif ();

    fplc_pkg::fplc_key_t key_state;
    fplc_pkg::fplc_mode_t mode;
    fplc_pkg::fplc_mode_t arm_mode;
    logic latch_space_select;
    logic program_in_progress;
    logic launch_sequence_error;
    logic latch_loaded_flag;
    logic ctrl_wr, stat_wr, other_wr;
    logic [3:0] key;
    fplc_pkg::fplc_mode_t wr_mode;
    logic launch_ok, launch_err, latch_wr;

    fplc_latch_buf #(.DEPTH(fplc_pkg::PAGE_BYTES)) u_buf (
        .clk(clk),
        .nrst(nrst),
        .lif(lif)
    );

    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    assign ctrl_wr = sfr_wr && sfr_addr == fplc_pkg::ADDR_FLASH_CONTROL_REG;
    assign stat_wr = sfr_wr && sfr_addr == fplc_pkg::ADDR_FLASH_STATUS_REG;
    assign other_wr = sfr_wr && !ctrl_wr;
    assign key = sfr_wdata[fplc_pkg::CTRL_KEY_HI:fplc_pkg::CTRL_KEY_LO];
    assign wr_mode = fplc_pkg::fplc_mode_t'(sfr_wdata[fplc_pkg::CTRL_MODE_HI:fplc_pkg::CTRL_MODE_LO]);

    always_comb begin
        launch_ok = 1'b0;
        launch_err = 1'b0;
        unique case (key_state)
            fplc_pkg::KEY_IDLE: begin
                launch_err = ctrl_wr && key == fplc_pkg::KEY_GO;
            end
            fplc_pkg::KEY_ARMED: begin
                if (ctrl_wr && key == fplc_pkg::KEY_GO) begin
                    if (wr_mode == arm_mode && !program_in_progress &&
                        (wr_mode == fplc_pkg::MODE_CLR || latch_loaded_flag)) begin
                        launch_ok = 1'b1;
                    end else begin
                        launch_err = 1'b1;
                    end
                end else if (ctrl_wr && key != fplc_pkg::KEY_ARM) begin
                    launch_err = 1'b1;
                end else if (other_wr) begin
                    launch_err = 1'b1;
                end
            end
        endcase
    end

    // ------------------------------------------------------------------
    // key sequence and control register
    // ------------------------------------------------------------------
    // key taken from control writes
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            key_state <= fplc_pkg::KEY_IDLE;
            arm_mode <= fplc_pkg::MODE_USER;
        end else if (ctrl_wr && key == fplc_pkg::KEY_ARM) begin
            key_state <= fplc_pkg::KEY_ARMED;
            arm_mode <= wr_mode;
        end else if (sfr_wr) begin
            key_state <= fplc_pkg::KEY_IDLE;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            latch_space_select <= fplc_pkg::FLASH_CONTROL_RESET[fplc_pkg::CTRL_LATCH_SPACE_BIT];
            mode <= fplc_pkg::MODE_USER;
        end else if (ctrl_wr) begin
            latch_space_select <= sfr_wdata[fplc_pkg::CTRL_LATCH_SPACE_BIT];
            mode <= wr_mode;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            program_in_progress <= fplc_pkg::FLASH_CONTROL_RESET[fplc_pkg::CTRL_BUSY_BIT];
        end else if (launch_ok && wr_mode != fplc_pkg::MODE_CLR) begin
            program_in_progress <= 1'b1;
        end else if (prog_done) begin
            program_in_progress <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // status flags
    // ------------------------------------------------------------------
    // set wins over clears
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            launch_sequence_error <= fplc_pkg::FLASH_STATUS_RESET[fplc_pkg::STAT_LAUNCH_SEQUENCE_ERROR_BIT];
        end else if (launch_err) begin
            launch_sequence_error <= 1'b1;
        end else if (launch_ok) begin
            launch_sequence_error <= 1'b0;
        end else if (stat_wr && !sfr_wdata[fplc_pkg::STAT_LAUNCH_SEQUENCE_ERROR_BIT]) begin
            launch_sequence_error <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            latch_loaded_flag <= fplc_pkg::FLASH_STATUS_RESET[fplc_pkg::STAT_LOADED_BIT];
        end else if (latch_wr) begin
            latch_loaded_flag <= 1'b1;
        end else if (launch_ok) begin
            latch_loaded_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sfr_rdata <= 8'h00;
        end else if (sfr_rd && sfr_addr == fplc_pkg::ADDR_FLASH_STATUS_REG) begin
            sfr_rdata <= {6'h00, launch_sequence_error, latch_loaded_flag};
        end else if (sfr_rd && sfr_addr == fplc_pkg::ADDR_FLASH_CONTROL_REG) begin
            sfr_rdata <= {4'h0, latch_space_select, mode, program_in_progress};
        end else begin
            sfr_rdata <= 8'h00;
        end
    end

    // ------------------------------------------------------------------
    // column latch writes and programming launch
    // ------------------------------------------------------------------
    // latch space redirect
    assign latch_wr = xdata_wr && latch_space_select && !program_in_progress;
    assign lif.wr_en = latch_wr;
    assign lif.wr_idx = xdata_addr[fplc_pkg::BYTE_IDX_W-1:0];
    assign lif.wr_data = xdata_wdata;
    assign lif.clr = (launch_ok && wr_mode == fplc_pkg::MODE_CLR) || prog_done;
    assign lif.rd_idx = prog_rd_idx;
    assign prog_rd_data = lif.rd_data;
    assign prog_rd_valid = lif.rd_valid;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prog_page <= 9'h000;
        end else if (latch_wr) begin
            prog_page <= xdata_addr[15:fplc_pkg::BYTE_IDX_W];
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prog_start <= 1'b0;
            prog_mode <= fplc_pkg::MODE_USER;
        end else begin
            prog_start <= launch_ok && wr_mode != fplc_pkg::MODE_CLR;
            if (launch_ok) begin
                prog_mode <= wr_mode;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            xram_wr_int <= 1'b0;
            xram_wr_ext <= 1'b0;
            xram_addr <= 16'h0000;
            xram_wdata <= 8'h00;
        end else begin
            xram_wr_int <= xdata_wr && !latch_space_select && !external_ram_select;
            xram_wr_ext <= xdata_wr && !latch_space_select && external_ram_select;
            xram_addr <= xdata_addr;
            xram_wdata <= xdata_wdata;
        end
    end

    // ------------------------------------------------------------------
    // code space read steering
    // ------------------------------------------------------------------
    // user array by default
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            code_rd_en <= 1'b0;
            code_rd_space <= fplc_pkg::MODE_USER;
            code_rd_addr <= 16'h0000;
        end else begin
            code_rd_en <= code_rd;
            code_rd_addr <= code_addr;
            if (mode == fplc_pkg::MODE_XROW && code_addr >= fplc_pkg::XROW_BASE) begin
                code_rd_space <= fplc_pkg::MODE_XROW;
            end else if (mode == fplc_pkg::MODE_HSB && code_addr == fplc_pkg::HSB_ADDR) begin
                code_rd_space <= fplc_pkg::MODE_HSB;
            end else if (mode == fplc_pkg::MODE_CLR) begin
                code_rd_space <= fplc_pkg::MODE_CLR;
            end else begin
                code_rd_space <= fplc_pkg::MODE_USER;
            end
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    a_go_unarmed: assert property (key_state == fplc_pkg::KEY_IDLE && ctrl_wr && key == fplc_pkg::KEY_GO |=> launch_sequence_error)
        else $error("go key without arm did not flag error");
    a_good_clears: assert property (launch_ok |=> !launch_sequence_error)
        else $error("good launch left error set");
    a_loaded_set: assert property (latch_wr |=> latch_loaded_flag ##0 prog_page == $past(xdata_addr[15:7]))
        else $error("latch write did not mark loaded or page");
    a_user_default: assert property (code_rd && mode == fplc_pkg::MODE_USER |=> code_rd_en && code_rd_space == fplc_pkg::MODE_USER)
        else $error("user mode read not steered to user array");
    a_latch_redirect: assert property (xdata_wr && latch_space_select |=> !xram_wr_int && !xram_wr_ext)
        else $error("latch space write leaked to data memory");
    a_xrow_map: assert property (code_rd && mode == fplc_pkg::MODE_XROW && code_addr >= 16'hff80 |=> code_rd_space == fplc_pkg::MODE_XROW)
        else $error("extra row read not steered");
    a_launch_start: assert property (launch_ok && wr_mode != fplc_pkg::MODE_CLR |=> prog_start && program_in_progress ##1 !prog_start)
        else $error("launch did not start programming");
    a_busy_hw_only: assert property (ctrl_wr && !launch_ok && !prog_done |=> program_in_progress == $past(program_in_progress))
        else $error("software changed busy flag");
    a_empty_launch: assert property (key_state == fplc_pkg::KEY_ARMED && ctrl_wr && key == fplc_pkg::KEY_GO && !latch_loaded_flag && wr_mode != fplc_pkg::MODE_CLR |=> launch_sequence_error && !prog_start)
        else $error("empty latch launch not flagged");
    a_status_zero: assert property (sfr_rd && sfr_addr == 8'hd3 |=> sfr_rdata[7:2] == 6'h00)
        else $error("unused status bits not zero");

    c_program: cover property (launch_ok && wr_mode == fplc_pkg::MODE_USER ##[1:300] prog_done);
    c_seq_error: cover property (launch_err);
    c_latch_reset: cover property (launch_ok && wr_mode == fplc_pkg::MODE_CLR);
endmodule
`default_nettype wire

// ---- logic/fplc_pkg.sv ----
// constants and types shared by the flash launch control block
// assumes a single system clock shared with the cpu core
`default_nettype none
package fplc_pkg;
    // ------------------------------------------------------------------
    // special function register map
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_FLASH_CONTROL_REG = 8'hd1;
    localparam logic [7:0] ADDR_FLASH_STATUS_REG = 8'hd3;
    localparam logic [7:0] FLASH_CONTROL_RESET = 8'h00;
    localparam logic [7:0] FLASH_STATUS_RESET = 8'h00;
    // control register fields
    localparam int CTRL_KEY_HI = 7;
    localparam int CTRL_KEY_LO = 4;
    localparam int CTRL_LATCH_SPACE_BIT = 3;
    localparam int CTRL_MODE_HI = 2;
    localparam int CTRL_MODE_LO = 1;
    localparam int CTRL_BUSY_BIT = 0;
    // status register fields
    localparam int STAT_LAUNCH_SEQUENCE_ERROR_BIT = 1;
    localparam int STAT_LOADED_BIT = 0;
    // launch key nibbles
    localparam logic [3:0] KEY_ARM = 4'h5;
    localparam logic [3:0] KEY_GO = 4'ha;
    // ------------------------------------------------------------------
    // page and address layout
    // ------------------------------------------------------------------
    localparam int PAGE_BYTES = 128;
    localparam int BYTE_IDX_W = 7;
    localparam int PAGE_W = 9;
    localparam logic [15:0] XROW_BASE = 16'hff80;
    localparam logic [15:0] HSB_ADDR = 16'h0000;

    typedef enum logic [1:0] {
        MODE_USER = 2'b00,
        MODE_XROW = 2'b01,
        MODE_HSB = 2'b10,
        MODE_CLR = 2'b11
    } fplc_mode_t;

    typedef enum logic {
        KEY_IDLE = 1'b0,
        KEY_ARMED = 1'b1
    } fplc_key_t;
endpackage
`default_nettype wire

// ---- logic/fplc_latch_if.sv ----
// carrier between the launch controller and the column latch buffer
// assumes both ends run on the same clock
`default_nettype none
interface fplc_latch_if;
    logic wr_en;
    logic [6:0] wr_idx;
    logic [7:0] wr_data;
    logic clr;
    logic [6:0] rd_idx;
    logic [7:0] rd_data;
    logic rd_valid;

    modport ctrl (output wr_en, wr_idx, wr_data, clr, rd_idx, input rd_data, rd_valid);
    modport store (input wr_en, wr_idx, wr_data, clr, rd_idx, output rd_data, rd_valid);
endinterface
`default_nettype wire

// ---- logic/fplc_latch_buf.sv ----
// column latch page buffer with per-byte loaded marks
// assumes clr and wr_en come from the controller on the same clock
`default_nettype none
module fplc_latch_buf #(
    parameter int DEPTH = fplc_pkg::PAGE_BYTES
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // controller side
    fplc_latch_if.store lif
);
    logic [7:0] mem [DEPTH];
    logic [DEPTH-1:0] valid;

    // ------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------
    // one page staging
    always_ff @(posedge clk) begin
        if (lif.wr_en && !lif.clr) begin
            mem[lif.wr_idx] <= lif.wr_data;
        end
    end

    genvar i;
    generate
        for (i = 0; i < DEPTH; i++) begin : g_valid
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    valid[i] <= 1'b0;
                end else if (lif.clr) begin
                    valid[i] <= 1'b0;
                end else if (lif.wr_en && lif.wr_idx == i) begin
                    valid[i] <= 1'b1;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            lif.rd_data <= 8'h00;
            lif.rd_valid <= 1'b0;
        end else begin
            lif.rd_data <= mem[lif.rd_idx];
            lif.rd_valid <= valid[lif.rd_idx];
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    a_clear_empties: assert property (lif.clr |=> valid == '0)
        else $error("latch reset left bytes marked");
    a_write_marks: assert property (lif.wr_en && !lif.clr |=> valid[$past(lif.wr_idx)])
        else $error("written latch byte not marked");
endmodule
`default_nettype wire

// ---- verification/fplc_engine_model.sv ----
// programming engine model: answers a start pulse, scans the page latches
// assumes prog_rd_data and prog_rd_valid follow prog_rd_idx one cycle late
`default_nettype none
module fplc_engine_model #(
    parameter int DELAY = 140
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // controller side
    input wire logic prog_start,
    input wire logic [7:0] prog_rd_data,
    input wire logic prog_rd_valid,
    output logic prog_done,
    output logic [6:0] prog_rd_idx,
    // scan results for the bench
    output logic [7:0] loaded_cnt,
    output logic [7:0] data_sum
);
    timeunit 1ns;
    timeprecision 1ps;
    logic active;
    int cnt;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            active <= 1'b0;
            cnt <= 0;
            prog_done <= 1'b0;
            loaded_cnt <= 8'h00;
            data_sum <= 8'h00;
        end else begin
            prog_done <= 1'b0;
            if (prog_start) begin
                active <= 1'b1;
                cnt <= 0;
                loaded_cnt <= 8'h00;
                data_sum <= 8'h00;
            end else if (active) begin
                cnt <= cnt + 1;
                if (cnt >= 1 && cnt <= 128 && prog_rd_valid === 1'b1) begin
                    loaded_cnt <= loaded_cnt + 8'h01;
                    data_sum <= data_sum + prog_rd_data;
                end
                if (cnt == DELAY) begin
                    active <= 1'b0;
                    prog_done <= 1'b1;
                end
            end
        end
    end
    assign prog_rd_idx = cnt[6:0];
endmodule
`default_nettype wire

// ---- verification/testbench.sv ----
// self-checking bench for the flash launch control block
// assumes the engine model stands in for the programming engine
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] CTL = fplc_pkg::ADDR_FLASH_CONTROL_REG;
    localparam logic [7:0] STA = fplc_pkg::ADDR_FLASH_STATUS_REG;
    typedef struct packed {
        logic [7:0] ctl;
        logic eram;
        logic [15:0] addr;
        logic [1:0] sp;
        logic wi;
        logic we;
    } fplc_row_t;
    localparam fplc_row_t ROWS [8] = '{
        '{8'h00, 1'b0, 16'h1234, 2'b00, 1'b1, 1'b0},
        '{8'h00, 1'b1, 16'h1234, 2'b00, 1'b0, 1'b1},
        '{8'h02, 1'b0, 16'hff90, 2'b01, 1'b1, 1'b0},
        '{8'h02, 1'b1, 16'h0010, 2'b00, 1'b0, 1'b1},
        '{8'h04, 1'b0, 16'h0000, 2'b10, 1'b1, 1'b0},
        '{8'h04, 1'b0, 16'h0005, 2'b00, 1'b1, 1'b0},
        '{8'h06, 1'b1, 16'h4000, 2'b11, 1'b0, 1'b1},
        '{8'h08, 1'b1, 16'hfff3, 2'b00, 1'b0, 1'b0}};
    logic clk, nrst, sfr_wr, sfr_rd, external_ram_select, code_rd, xdata_wr, prog_done;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, xdata_wdata, xram_wdata, prog_rd_data;
    logic [15:0] code_addr, code_rd_addr, xdata_addr, xram_addr;
    logic code_rd_en, xram_wr_int, xram_wr_ext, prog_start, prog_rd_valid;
    logic [6:0] prog_rd_idx;
    logic [8:0] prog_page;
    logic [7:0] loaded_cnt, data_sum;
    fplc_pkg::fplc_mode_t code_rd_space, prog_mode;
    int err_total = 0;
    int total_checks = 0;
    int cycles = 0;

    fplc_top i_dut (.clk(clk), .nrst(nrst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .external_ram_select(external_ram_select), .code_rd(code_rd), .code_addr(code_addr),
        .code_rd_en(code_rd_en), .code_rd_space(code_rd_space), .code_rd_addr(code_rd_addr),
        .xdata_wr(xdata_wr), .xdata_addr(xdata_addr), .xdata_wdata(xdata_wdata),
        .xram_wr_int(xram_wr_int), .xram_wr_ext(xram_wr_ext), .xram_addr(xram_addr),
        .xram_wdata(xram_wdata), .prog_done(prog_done), .prog_rd_idx(prog_rd_idx),
        .prog_start(prog_start), .prog_mode(prog_mode), .prog_page(prog_page),
        .prog_rd_data(prog_rd_data), .prog_rd_valid(prog_rd_valid));
    fplc_engine_model i_engine (.clk(clk), .nrst(nrst), .prog_start(prog_start),
        .prog_rd_data(prog_rd_data), .prog_rd_valid(prog_rd_valid), .prog_done(prog_done),
        .prog_rd_idx(prog_rd_idx), .loaded_cnt(loaded_cnt), .data_sum(data_sum));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
        // a free cycle first keeps back to back strobes apart
        @(negedge clk);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge clk);
        sfr_wr = 1'b0;
    endtask
    task automatic sfr_read(input logic [7:0] a, input logic [7:0] exp, input string name);
        @(negedge clk);
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(negedge clk);
        sfr_rd = 1'b0;
        check(name, {8'h00, exp}, {8'h00, sfr_rdata});
    endtask
    task automatic xwrite(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk);
        xdata_addr = a;
        xdata_wdata = d;
        xdata_wr = 1'b1;
        @(negedge clk);
        xdata_wr = 1'b0;
    endtask
    task automatic wait_done();
        int i;
        for (i = 0; i < 400 && prog_done !== 1'b1; i++) @(negedge clk);
        check("done seen", 16'h0001, {15'h0, prog_done});
        @(negedge clk);
    endtask
    task automatic test_done();
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            $display("unexpected timeout expected %0d seen %0d", 0, cycles);
            test_done();
        end
    end

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        nrst = 1'b0;
        {sfr_wr, sfr_rd, external_ram_select, code_rd, xdata_wr} = 5'h00;
        {sfr_addr, sfr_wdata, xdata_wdata} = 24'h000000;
        {code_addr, xdata_addr} = 32'h00000000;
        repeat (3) @(negedge clk);
        nrst = 1'b1;
        @(negedge clk);
        foreach (ROWS[i]) begin
            external_ram_select = ROWS[i].eram;
            sfr_write(CTL, ROWS[i].ctl);
            sfr_read(CTL, ROWS[i].ctl, "control");
            code_addr = ROWS[i].addr;
            code_rd = 1'b1;
            @(negedge clk);
            code_rd = 1'b0;
            check("code en", 16'h0001, {15'h0, code_rd_en});
            check("space", {14'h0, ROWS[i].sp}, {14'h0, code_rd_space});
            check("code addr", ROWS[i].addr, code_rd_addr);
            xwrite(ROWS[i].addr, 8'h5a);
            check("xram strobes", {14'h0, ROWS[i].wi, ROWS[i].we},
                {14'h0, xram_wr_int, xram_wr_ext});
            check("xram addr", ROWS[i].addr, xram_addr);
            check("xram data", 16'h005a, {8'h00, xram_wdata});
        end
        check("page", 16'h01ff, {7'h0, prog_page});
        nrst = 1'b0;
        repeat (3) @(negedge clk);
        nrst = 1'b1;
        @(negedge clk);
        sfr_read(STA, 8'h00, "status reset");
        sfr_read(CTL, 8'h00, "control reset");
        sfr_read(8'h80, 8'h00, "unmapped");
        sfr_write(CTL, 8'h50);
        sfr_write(CTL, 8'ha0);
        check("start on empty", 16'h0000, {15'h0, prog_start});
        sfr_read(STA, 8'h02, "empty launch");
        sfr_write(STA, 8'hff);
        sfr_read(STA, 8'h02, "status ones");
        sfr_write(STA, 8'h00);
        sfr_read(STA, 8'h00, "software clear");
        external_ram_select = 1'b1;
        sfr_write(CTL, 8'h08);
        xwrite(16'h1234, 8'h3c);
        check("latch strobes", 16'h0000, {14'h0, xram_wr_int, xram_wr_ext});
        check("page a", 16'h0024, {7'h0, prog_page});
        sfr_read(STA, 8'h01, "loaded");
        xwrite(16'h0000, 8'h22);
        xwrite(16'hffb4, 8'h11);
        check("page b", 16'h01ff, {7'h0, prog_page});
        sfr_write(CTL, 8'h58);
        sfr_write(STA, 8'h00);
        sfr_read(STA, 8'h03, "broken key");
        sfr_write(CTL, 8'h58);
        sfr_write(CTL, 8'ha8);
        check("start", 16'h0001, {15'h0, prog_start});
        check("mode", 16'h0000, {14'h0, prog_mode});
        sfr_read(STA, 8'h00, "good launch");
        xwrite(16'h0005, 8'h77);
        check("busy drop", 16'h0000, {14'h0, xram_wr_int, xram_wr_ext});
        sfr_write(CTL, 8'h08);
        sfr_read(CTL, 8'h09, "busy held");
        wait_done();
        check("bytes", 16'h0002, {8'h0, loaded_cnt});
        check("sum", 16'h0033, {8'h0, data_sum});
        sfr_read(CTL, 8'h08, "busy clear");
        xwrite(16'h0040, 8'h55);
        sfr_write(CTL, 8'h5e);
        sfr_write(CTL, 8'hae);
        check("clear no start", 16'h0000, {15'h0, prog_start});
        sfr_read(STA, 8'h00, "clear launch");
        sfr_write(CTL, 8'h58);
        sfr_write(CTL, 8'ha8);
        sfr_read(STA, 8'h02, "latches emptied");
        xwrite(16'h0001, 8'h01);
        sfr_write(CTL, 8'h58);
        sfr_write(CTL, 8'haa);
        sfr_read(STA, 8'h03, "mode mismatch");
        // arm key again while armed: the later mode is the one launched
        sfr_write(CTL, 8'h58);
        sfr_write(CTL, 8'h5a);
        sfr_write(CTL, 8'haa);
        check("rearm start", 16'h0001, {15'h0, prog_start});
        check("rearm mode", 16'h0001, {14'h0, prog_mode});
        wait_done();
        check("rearm bytes", 16'h0001, {8'h0, loaded_cnt});
        sfr_read(STA, 8'h00, "rearm status");
        for (int m = 0; m < 3; m++) begin
            xwrite(16'h0001, 8'h01);
            sfr_write(CTL, {4'h5, 1'b1, m[1:0], 1'b0});
            sfr_write(CTL, {4'ha, 1'b1, m[1:0], 1'b0});
            check("mode start", 16'h0001, {15'h0, prog_start});
            check("mode sel", {14'h0, m[1:0]}, {14'h0, prog_mode});
            wait_done();
            check("mode bytes", 16'h0001, {8'h0, loaded_cnt});
            sfr_read(STA, 8'h00, "mode status");
        end
        test_done();
    end
endmodule
`default_nettype wire
